// ===== shared/dspmc_pkg.sv
/*
  Constants, mode encodings and wake timings for the dual subsystem power-mode controller.
  Assumes a single 125 MHz system clock; all latencies are counted in its cycles.
  Operation list:
*/
// Operation
// - active mode runs processor at full 80 MHz
// - sleep gates clocks, keeps all state, instant resume
// - sleep wakes on fast timer, pin, peripheral
// - deep sleep keeps config registers, chosen memory
// - deep sleep recovery finishes under 3 ms
// - deep sleep wakes on RTC or subset pins
// - hibernate gates all but always-on section, RTC
// - hibernate wakes on RTC or pin event
// - hibernate wake 15 ms plus flash reload
// - shutdown turns all off; return takes 1.1 s
// - power level falls strictly down the modes
// - network processor sequences its own sleep
// - link-only mode handles management frames, no IP
// - listen mode accepts beacons only
// - connected idle sleeps between beacons, repeats
// - network deep sleep keeps state for next beacon
package dspmc_pkg;

  // ==========================================================
  // clock and wake timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PROC_CLK_MHZ = 80;
  localparam int unsigned RDS_WAKE_MAX_US = 3000;
  localparam int unsigned HIB_WAKE_US = 15000;
  localparam int unsigned SHDN_WAKE_US = 1100000;
  // strictly under the limit, so one cycle short of it
  localparam int unsigned RDS_WAKE_CYC = RDS_WAKE_MAX_US * CLK_MHZ - 1;
  localparam int unsigned HIB_WAKE_CYC = HIB_WAKE_US * CLK_MHZ;
  localparam int unsigned SHDN_WAKE_CYC = SHDN_WAKE_US * CLK_MHZ;
  localparam int unsigned WAKE_CNT_W = 28;

  // ==========================================================
  // sizes and reset values
  localparam int unsigned GPIO_N = 27;
  localparam int unsigned MEM_BANKS = 4;
  localparam int unsigned CFG_W = 32;
  localparam logic [26:0] RDS_GPIO_SUBSET_RST = 27'h000003F;
  localparam logic [CFG_W-1:0] CFG_RETAIN_RST = 32'h00000000;

  // ==========================================================
  // power levels, highest draw first
  localparam logic [2:0] PWR_ACTIVE = 3'h4;
  localparam logic [2:0] PWR_SLEEP = 3'h3;
  localparam logic [2:0] PWR_RDS = 3'h2;
  localparam logic [2:0] PWR_HIB = 3'h1;
  localparam logic [2:0] PWR_OFF = 3'h0;

  // ==========================================================
  // mode encodings
  typedef enum logic [1:0] {
    DSPMC_REQ_SLEEP = 2'h0,
    DSPMC_REQ_RETAINED_DEEP_SLEEP = 2'h1,
    DSPMC_REQ_HIBERNATE = 2'h2,
    DSPMC_REQ_NONE = 2'h3
  } dspmc_req_e;

  typedef enum logic [3:0] {
    DSPMC_APP_SHUTDOWN = 4'h0,
    DSPMC_APP_POWERUP = 4'h1,
    DSPMC_APP_ACTIVE = 4'h2,
    DSPMC_APP_SLEEP = 4'h3,
    DSPMC_APP_RDS = 4'h4,
    DSPMC_APP_RDS_WAKE = 4'h5,
    DSPMC_APP_HIB = 4'h6,
    DSPMC_APP_HIB_WAKE = 4'h7,
    DSPMC_APP_RELOAD = 4'h8
  } dspmc_app_e;

  typedef enum logic [2:0] {
    DSPMC_NET_DISABLED = 3'h0,
    DSPMC_NET_ACTIVE_IP = 3'h1,
    DSPMC_NET_ACTIVE_LINK = 3'h2,
    DSPMC_NET_LISTEN = 3'h3,
    DSPMC_NET_RDS = 3'h4
  } dspmc_net_e;

endpackage : dspmc_pkg

// ===== core/dspmc_ctrl.sv
/*
  Power-mode controller for an application processor and a network processor.
  Assumes all inputs are synchronous to sys_clk; the reset pin level is already clean.
*/
`timescale 1ns/1ns
module dspmc_ctrl #(
  parameter int unsigned RDS_WAKE_CYCLES = dspmc_pkg::RDS_WAKE_CYC,
  parameter int unsigned HIB_WAKE_CYCLES = dspmc_pkg::HIB_WAKE_CYC,
  parameter int unsigned SHDN_WAKE_CYCLES = dspmc_pkg::SHDN_WAKE_CYC,
  parameter logic [dspmc_pkg::GPIO_N-1:0] RDS_GPIO_SUBSET = dspmc_pkg::RDS_GPIO_SUBSET_RST
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // external reset pin
  input wire logic active_low_reset_pin,
  // user program mode request
  input wire logic mode_req_valid,
  input wire dspmc_pkg::dspmc_req_e mode_req,
  // wake configuration
  input wire logic sleep_timer_wake_en,
  input wire logic sleep_periph_wake_en,
  input wire logic [dspmc_pkg::GPIO_N-1:0] sleep_gpio_wake_mask,
  input wire logic rds_rtc_wake_en,
  input wire logic [dspmc_pkg::GPIO_N-1:0] rds_gpio_wake_mask,
  input wire logic hib_rtc_wake_en,
  input wire logic [dspmc_pkg::GPIO_N-1:0] hib_gpio_wake_mask,
  input wire logic [dspmc_pkg::MEM_BANKS-1:0] mem_retain_sel,
  input wire logic [dspmc_pkg::CFG_W-1:0] cfg_live,
  // wake events
  input wire logic fast_timer_expired,
  input wire logic periph_activity,
  input wire logic rtc_expired,
  input wire logic [dspmc_pkg::GPIO_N-1:0] gpio_event,
  input wire logic flash_reload_done,
  // network processor control and traffic
  input wire logic net_enable,
  input wire logic net_power_save_en,
  input wire logic net_ip_traffic,
  input wire logic net_link_traffic,
  input wire logic beacon_due,
  input wire logic frame_valid,
  input wire logic frame_is_beacon,
  input wire logic beacon_traffic_pending,
  // application side status and power controls
  output dspmc_pkg::dspmc_app_e app_mode,
  output logic [2:0] power_level,
  output logic proc_clk_en,
  output logic [7:0] proc_clk_mhz,
  output logic core_power_en,
  output logic aon_power_en,
  output logic rtc_run,
  output logic state_retain,
  output logic [dspmc_pkg::MEM_BANKS-1:0] mem_retain_en,
  output logic [dspmc_pkg::CFG_W-1:0] cfg_retained,
  output logic flash_reload_req,
  output logic wake_event,
  // network side status
  output dspmc_pkg::dspmc_net_e net_mode,
  output logic net_ip_proc_en,
  output logic net_state_retain,
  output logic frame_accept,
  output logic frame_reject
);
  import dspmc_pkg::*;

  // ==========================================================
  // state
  dspmc_app_e app_state;
  dspmc_app_e next_app_state;
  dspmc_net_e net_state;
  dspmc_net_e next_net_state;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic [WAKE_CNT_W-1:0] next_wake_cnt;
  logic [CFG_W-1:0] cfg_hold;
  logic [MEM_BANKS-1:0] retain_banks;
  logic frame_acc;
  logic frame_rej;
  logic wake_pulse;

  // ==========================================================
  // wake decoding
  wire logic pin_off = ~active_low_reset_pin;
  wire logic in_active = (app_state == DSPMC_APP_ACTIVE);
  // requests accepted only in active mode
  wire logic req_take = mode_req_valid & in_active & (mode_req != DSPMC_REQ_NONE);
  wire logic sleep_wake = (sleep_timer_wake_en & fast_timer_expired)
    | (sleep_periph_wake_en & periph_activity)
    | (|(gpio_event & sleep_gpio_wake_mask));
  wire logic rds_wake = (rds_rtc_wake_en & rtc_expired)
    | (|(gpio_event & rds_gpio_wake_mask & RDS_GPIO_SUBSET));
  wire logic hib_wake = (hib_rtc_wake_en & rtc_expired)
    | (|(gpio_event & hib_gpio_wake_mask));
  wire logic cnt_zero = (wake_cnt == '0);
  wire logic [WAKE_CNT_W-1:0] rds_load = WAKE_CNT_W'(RDS_WAKE_CYCLES - 1);
  wire logic [WAKE_CNT_W-1:0] hib_load = WAKE_CNT_W'(HIB_WAKE_CYCLES - 1);
  wire logic [WAKE_CNT_W-1:0] shdn_load = WAKE_CNT_W'(SHDN_WAKE_CYCLES - 1);
  wire logic cnt_dec = (app_state == DSPMC_APP_POWERUP) | (app_state == DSPMC_APP_RDS_WAKE)
    | (app_state == DSPMC_APP_HIB_WAKE);

  // ==========================================================
  // application mode sequencer
  always_comb begin
    next_app_state = app_state;
    next_wake_cnt = (cnt_dec && !cnt_zero) ? wake_cnt - 1'b1 : wake_cnt;
    if (pin_off) begin
      // pin low forces shutdown from any mode
      next_app_state = DSPMC_APP_SHUTDOWN;
      next_wake_cnt = '0;
    end else begin
      unique case (app_state)
        DSPMC_APP_SHUTDOWN: begin
          next_app_state = DSPMC_APP_POWERUP;
          next_wake_cnt = shdn_load;
        end
        DSPMC_APP_POWERUP: begin
          if (cnt_zero) begin
            next_app_state = DSPMC_APP_RELOAD;
          end
        end
        DSPMC_APP_ACTIVE: begin
          if (req_take) begin
            unique case (mode_req)
              DSPMC_REQ_SLEEP: next_app_state = DSPMC_APP_SLEEP;
              DSPMC_REQ_RETAINED_DEEP_SLEEP: next_app_state = DSPMC_APP_RDS;
              DSPMC_REQ_HIBERNATE: next_app_state = DSPMC_APP_HIB;
              DSPMC_REQ_NONE: next_app_state = DSPMC_APP_ACTIVE;
            endcase
          end
        end
        DSPMC_APP_SLEEP: begin
          // clocks return at once since nothing was lost
          if (sleep_wake) begin
            next_app_state = DSPMC_APP_ACTIVE;
          end
        end
        DSPMC_APP_RDS: begin
          if (rds_wake) begin
            next_app_state = DSPMC_APP_RDS_WAKE;
            next_wake_cnt = rds_load;
          end
        end
        DSPMC_APP_RDS_WAKE: begin
          if (cnt_zero) begin
            next_app_state = DSPMC_APP_ACTIVE;
          end
        end
        DSPMC_APP_HIB: begin
          if (hib_wake) begin
            next_app_state = DSPMC_APP_HIB_WAKE;
            next_wake_cnt = hib_load;
          end
        end
        DSPMC_APP_HIB_WAKE: begin
          if (cnt_zero) begin
            next_app_state = DSPMC_APP_RELOAD;
          end
        end
        DSPMC_APP_RELOAD: begin
          // image reload time depends on code size, so wait for flash
          if (flash_reload_done) begin
            next_app_state = DSPMC_APP_ACTIVE;
          end
        end
        default: begin
          next_app_state = DSPMC_APP_SHUTDOWN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      app_state <= DSPMC_APP_SHUTDOWN;
      wake_cnt <= '0;
    end else begin
      app_state <= next_app_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  // ==========================================================
  // retention capture on deep sleep entry
  wire logic rds_enter = req_take & (mode_req == DSPMC_REQ_RETAINED_DEEP_SLEEP) & ~pin_off;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_hold <= CFG_RETAIN_RST;
      retain_banks <= '0;
    end else if (pin_off) begin
      cfg_hold <= CFG_RETAIN_RST;
      retain_banks <= '0;
    end else if (rds_enter) begin
      cfg_hold <= cfg_live;
      retain_banks <= mem_retain_sel;
    end
  end

  // ==========================================================
  // network processor sequencer, independent of application requests
  always_comb begin
    next_net_state = net_state;
    frame_acc = 1'b0;
    frame_rej = 1'b0;
    if (pin_off || !net_enable) begin
      next_net_state = DSPMC_NET_DISABLED;
      frame_rej = frame_valid;
    end else begin
      unique case (net_state)
        DSPMC_NET_DISABLED: begin
          next_net_state = DSPMC_NET_ACTIVE_IP;
          frame_rej = frame_valid;
        end
        DSPMC_NET_ACTIVE_IP, DSPMC_NET_ACTIVE_LINK: begin
          frame_acc = frame_valid;
          if (net_ip_traffic) begin
            next_net_state = DSPMC_NET_ACTIVE_IP;
          end else if (net_link_traffic) begin
            next_net_state = DSPMC_NET_ACTIVE_LINK;
          end else if (net_power_save_en) begin
            next_net_state = DSPMC_NET_RDS;
          end
        end
        DSPMC_NET_LISTEN: begin
          frame_acc = frame_valid & frame_is_beacon;
          frame_rej = frame_valid & ~frame_is_beacon;
          if (frame_valid && frame_is_beacon) begin
            next_net_state = beacon_traffic_pending ? DSPMC_NET_ACTIVE_IP : DSPMC_NET_RDS;
          end
        end
        DSPMC_NET_RDS: begin
          frame_rej = frame_valid;
          if (beacon_due) begin
            next_net_state = DSPMC_NET_LISTEN;
          end
        end
        default: begin
          next_net_state = DSPMC_NET_DISABLED;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      net_state <= DSPMC_NET_DISABLED;
      frame_accept <= 1'b0;
      frame_reject <= 1'b0;
    end else begin
      net_state <= next_net_state;
      frame_accept <= frame_acc;
      frame_reject <= frame_rej;
    end
  end

  // ==========================================================
  // wake pulse when a low-power mode is left
  assign wake_pulse = ((app_state == DSPMC_APP_SLEEP) & sleep_wake)
    | ((app_state == DSPMC_APP_RDS) & rds_wake)
    | ((app_state == DSPMC_APP_HIB) & hib_wake);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= wake_pulse & ~pin_off;
    end
  end

  // ==========================================================
  // power control outputs decoded from the mode
  wire logic st_off = (app_state == DSPMC_APP_SHUTDOWN);
  wire logic st_sleep = (app_state == DSPMC_APP_SLEEP);
  wire logic st_rds = (app_state == DSPMC_APP_RDS);
  wire logic st_hib = (app_state == DSPMC_APP_HIB);
  wire logic st_pwrup = (app_state == DSPMC_APP_POWERUP);
  wire logic st_hwake = (app_state == DSPMC_APP_HIB_WAKE);

  assign app_mode = app_state;
  // full-rate clock only while executing
  assign proc_clk_en = in_active;
  assign proc_clk_mhz = in_active ? 8'(PROC_CLK_MHZ) : 8'h00;
  // core logic keeps power through sleep, dropped in deeper modes
  assign core_power_en = ~(st_off | st_rds | st_hib | st_hwake | st_pwrup);
  assign aon_power_en = ~st_off;
  assign rtc_run = ~st_off;
  assign state_retain = st_sleep;
  assign mem_retain_en = (st_rds | st_sleep) ? (st_sleep ? {MEM_BANKS{1'b1}} : retain_banks) : '0;
  assign cfg_retained = cfg_hold;
  assign flash_reload_req = (app_state == DSPMC_APP_RELOAD);
  assign power_level = st_off ? PWR_OFF
    : (st_hib | st_hwake | st_pwrup) ? PWR_HIB
    : (st_rds ? PWR_RDS : (st_sleep ? PWR_SLEEP : PWR_ACTIVE));

  assign net_mode = net_state;
  assign net_ip_proc_en = (net_state == DSPMC_NET_ACTIVE_IP);
  assign net_state_retain = (net_state == DSPMC_NET_RDS);

endmodule : dspmc_ctrl

// ===== test/dspmc_chk.sv
/*
  Port checker for dspmc_ctrl, bound into every instance.
  Assumes the bench sets a small deep sleep wake count.
*/
`timescale 1ns/1ns
module dspmc_chk #(
  parameter int unsigned RDS_WAKE_CYCLES = 10
) (
  // clock, reset, request
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic active_low_reset_pin,
  input wire logic mode_req_valid,
  input wire dspmc_pkg::dspmc_req_e mode_req,
  // wake and frame inputs
  input wire logic hib_rtc_wake_en,
  input wire logic rtc_expired,
  input wire logic net_enable,
  input wire logic beacon_due,
  input wire logic frame_valid,
  input wire logic frame_is_beacon,
  // watched outputs
  input wire dspmc_pkg::dspmc_app_e app_mode,
  input wire logic [2:0] power_level,
  input wire logic proc_clk_en,
  input wire logic [7:0] proc_clk_mhz,
  input wire logic aon_power_en,
  input wire logic rtc_run,
  input wire logic state_retain,
  input wire logic wake_event,
  input wire dspmc_pkg::dspmc_net_e net_mode,
  input wire logic net_state_retain,
  input wire logic frame_accept,
  input wire logic frame_reject
);
  import dspmc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] wake_cnt;
  // ==========================================
  // cycles spent waking from deep sleep
  always_ff @(posedge sys_clk) begin
    wake_cnt <= (app_mode == DSPMC_APP_RDS_WAKE) ? wake_cnt + 16'h0001 : 16'h0000;
  end
  sequence s_hib_wake;
    app_mode == DSPMC_APP_HIB_WAKE && wake_event ##1 app_mode == DSPMC_APP_HIB_WAKE;
  endsequence
  property p_act_clk; app_mode == DSPMC_APP_ACTIVE |-> proc_clk_en && proc_clk_mhz == 8'h50; endproperty
  a_act_clk: assert property (p_act_clk) else $error("active clock wrong");
  property p_sleep; app_mode == DSPMC_APP_SLEEP |-> !proc_clk_en && state_retain && power_level == PWR_SLEEP; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_req;
    mode_req_valid && mode_req == DSPMC_REQ_RETAINED_DEEP_SLEEP && app_mode == DSPMC_APP_ACTIVE && active_low_reset_pin
    |=> app_mode == DSPMC_APP_RDS && power_level == PWR_RDS;
  endproperty
  a_req: assert property (p_req) else $error("deep sleep request not taken");
  property p_pin;
    !active_low_reset_pin |=> app_mode == DSPMC_APP_SHUTDOWN && !rtc_run && !aon_power_en && net_mode == DSPMC_NET_DISABLED;
  endproperty
  a_pin: assert property (p_pin) else $error("pin low not shut down");
  property p_rds_time; wake_cnt <= RDS_WAKE_CYCLES; endproperty
  a_rds_time: assert property (p_rds_time) else $error("deep sleep wake too long");
  property p_hib; app_mode == DSPMC_APP_HIB && hib_rtc_wake_en && rtc_expired && active_low_reset_pin |=> s_hib_wake; endproperty
  a_hib: assert property (p_hib) else $error("hibernate wake wrong");
  property p_listen; net_mode == DSPMC_NET_LISTEN && frame_valid && !frame_is_beacon |=> frame_reject && !frame_accept; endproperty
  a_listen: assert property (p_listen) else $error("listen took non beacon");
  property p_cidle;
    net_mode == DSPMC_NET_RDS && beacon_due && net_enable && active_low_reset_pin |-> net_state_retain ##1 net_mode == DSPMC_NET_LISTEN;
  endproperty
  a_cidle: assert property (p_cidle) else $error("beacon wake wrong");
endmodule : dspmc_chk
bind dspmc_ctrl dspmc_chk #(.RDS_WAKE_CYCLES(RDS_WAKE_CYCLES)) dspmc_chk_i (.*);

// ===== test/dspmc_sw_model.sv
/*
  Model of the user program and the external reset pin.
  Assumes sys_clk is the controller clock; drives on its falling edge.
*/
`timescale 1ns/1ns
module dspmc_sw_model (
  // clock
  input wire logic sys_clk,
  // pin and mode request
  output logic active_low_reset_pin,
  output logic mode_req_valid,
  output dspmc_pkg::dspmc_req_e mode_req
);
  import dspmc_pkg::*;
  initial begin
    active_low_reset_pin = 1'h1;
    mode_req_valid = 1'h0;
    mode_req = DSPMC_REQ_NONE;
  end
  // one-cycle request, issued only by the program
  task automatic request(input dspmc_req_e m);
    @(negedge sys_clk);
    mode_req_valid = 1'h1;
    mode_req = m;
    @(negedge sys_clk);
    mode_req_valid = 1'h0;
    mode_req = DSPMC_REQ_NONE;
  endtask : request
  task automatic set_pin(input logic lvl);
    @(negedge sys_clk);
    active_low_reset_pin = lvl;
  endtask : set_pin
endmodule : dspmc_sw_model

// ===== test/tb.sv
/*
  Self-checking bench for the power-mode controller with short wake counts.
  Assumes the software model drives the pin and the mode requests.
*/
`timescale 1ns/1ns
module tb;
  import dspmc_pkg::*;
  localparam int LW = 10;
  localparam int HW = 20;
  localparam int SW = 30;
  logic sys_clk, sys_rst, sleep_timer_wake_en, sleep_periph_wake_en, rds_rtc_wake_en, hib_rtc_wake_en;
  logic fast_timer_expired, periph_activity, rtc_expired, flash_reload_done, net_enable, net_power_save_en;
  logic net_ip_traffic, net_link_traffic, beacon_due, frame_valid, frame_is_beacon, beacon_traffic_pending;
  logic [GPIO_N-1:0] sleep_gpio_wake_mask, rds_gpio_wake_mask, hib_gpio_wake_mask, gpio_event;
  logic [MEM_BANKS-1:0] mem_retain_sel, mem_retain_en;
  logic [CFG_W-1:0] cfg_live, cfg_retained;
  logic active_low_reset_pin, mode_req_valid, proc_clk_en, core_power_en, aon_power_en, rtc_run, state_retain;
  logic flash_reload_req, wake_event, net_ip_proc_en, net_state_retain, frame_accept, frame_reject;
  logic [2:0] power_level;
  logic [7:0] proc_clk_mhz;
  dspmc_req_e mode_req;
  dspmc_app_e app_mode;
  dspmc_net_e net_mode;
  int errors, n_compared, n;
  dspmc_ctrl #(.RDS_WAKE_CYCLES(LW), .HIB_WAKE_CYCLES(HW), .SHDN_WAKE_CYCLES(SW)) dspmc_ctrl_i (.*);
  dspmc_sw_model dspmc_sw_model_i (.*);
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k = 1);
    repeat (k) @(negedge sys_clk);
  endtask : tick
  task automatic wait_app(input dspmc_app_e m, input int lim);
    for (n = 0; app_mode !== m && n < lim; n++) begin
      tick();
    end
    if (n == lim) begin
      errors++;
    end
  endtask : wait_app
  task automatic reload_done();
    flash_reload_done = 1'h1;
    tick();
    flash_reload_done = 1'h0;
    chk({app_mode, proc_clk_en, proc_clk_mhz}, {DSPMC_APP_ACTIVE, 1'h1, 8'h50});
  endtask : reload_done
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // ==========================================
  // scenarios
  task automatic t_boot();
    wait_app(DSPMC_APP_RELOAD, SW + 5);
    chk({n inside {[SW - 1:SW + 3]}, flash_reload_req}, 2'h3);
    reload_done();
    $display("boot test done");
  endtask : t_boot
  task automatic t_sleep();
    for (int i = 0; i < 3; i++) begin
      dspmc_sw_model_i.request(DSPMC_REQ_SLEEP);
      chk({app_mode, proc_clk_en, state_retain, mem_retain_en, power_level},
        {DSPMC_APP_SLEEP, 2'h1, 4'hF, PWR_SLEEP});
      dspmc_sw_model_i.request(DSPMC_REQ_HIBERNATE);
      chk(app_mode, DSPMC_APP_SLEEP);
      {fast_timer_expired, periph_activity, gpio_event[20]} = 3'h4 >> i;
      tick();
      chk(app_mode, DSPMC_APP_SLEEP);
      {sleep_timer_wake_en, sleep_periph_wake_en, sleep_gpio_wake_mask[20]} = 3'h4 >> i;
      tick();
      chk({app_mode, wake_event}, {DSPMC_APP_ACTIVE, 1'h1});
      {fast_timer_expired, periph_activity, gpio_event[20]} = 3'h0;
      {sleep_timer_wake_en, sleep_periph_wake_en, sleep_gpio_wake_mask[20]} = 3'h0;
    end
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_rds();
    {mem_retain_sel, rds_rtc_wake_en, rds_gpio_wake_mask} = {4'hA, 1'h1, 27'h7FFFFFF};
    for (int j = 0; j < 2; j++) begin
      cfg_live = 32'h5A3C0F96 + j;
      dspmc_sw_model_i.request(DSPMC_REQ_RETAINED_DEEP_SLEEP);
      cfg_live = 32'h0;
      chk({app_mode, power_level, mem_retain_en, proc_clk_en}, {DSPMC_APP_RDS, PWR_RDS, 4'hA, 1'h0});
      chk(cfg_retained, 32'h5A3C0F96 + j);
      gpio_event[10] = 1'h1;
      tick();
      chk(app_mode, DSPMC_APP_RDS);
      gpio_event = '0;
      {rtc_expired, gpio_event[2]} = 2'h1 << j;
      tick();
      {rtc_expired, gpio_event[2]} = 2'h0;
      chk({app_mode, wake_event}, {DSPMC_APP_RDS_WAKE, 1'h1});
      wait_app(DSPMC_APP_ACTIVE, LW + 5);
      chk(n inside {[LW - 2:LW + 1]}, 1'h1);
    end
    $display("deep sleep test done");
  endtask : t_rds
  task automatic t_hib();
    {hib_rtc_wake_en, hib_gpio_wake_mask[3]} = 2'h3;
    for (int k = 0; k < 2; k++) begin
      dspmc_sw_model_i.request(DSPMC_REQ_HIBERNATE);
      chk({app_mode, power_level, core_power_en, aon_power_en, rtc_run}, {DSPMC_APP_HIB, PWR_HIB, 3'h3});
      {rtc_expired, gpio_event[3]} = 2'h1 << k;
      tick();
      {rtc_expired, gpio_event[3]} = 2'h0;
      chk({app_mode, wake_event}, {DSPMC_APP_HIB_WAKE, 1'h1});
      wait_app(DSPMC_APP_RELOAD, HW + 5);
      chk(n inside {[HW - 2:HW + 1]}, 1'h1);
      tick(3);
      chk({app_mode, flash_reload_req}, {DSPMC_APP_RELOAD, 1'h1});
      reload_done();
    end
    $display("hibernate test done");
  endtask : t_hib
  task automatic t_net();
    net_enable = 1'h1;
    tick();
    chk({net_mode, net_ip_proc_en}, {DSPMC_NET_ACTIVE_IP, 1'h1});
    net_link_traffic = 1'h1;
    tick();
    chk({net_mode, net_ip_proc_en}, {DSPMC_NET_ACTIVE_LINK, 1'h0});
    net_ip_traffic = 1'h1;
    tick();
    chk({net_mode, net_ip_proc_en}, {DSPMC_NET_ACTIVE_IP, 1'h1});
    net_ip_traffic = 1'h0;
    tick();
    chk({net_mode, net_ip_proc_en}, {DSPMC_NET_ACTIVE_LINK, 1'h0});
    {net_link_traffic, net_power_save_en} = 2'h1;
    tick();
    chk({net_mode, net_state_retain}, {DSPMC_NET_RDS, 1'h1});
    for (int c = 0; c < 2; c++) begin
      beacon_due = 1'h1;
      tick();
      beacon_due = 1'h0;
      chk(net_mode, DSPMC_NET_LISTEN);
      {frame_valid, frame_is_beacon} = 2'h2;
      tick();
      chk({net_mode, frame_accept, frame_reject}, {DSPMC_NET_LISTEN, 2'h1});
      {frame_valid, frame_is_beacon, beacon_traffic_pending} = {2'h3, c[0]};
      tick();
      {frame_valid, frame_is_beacon, beacon_traffic_pending} = 3'h0;
      chk({net_mode, frame_accept, frame_reject}, {c ? DSPMC_NET_ACTIVE_IP : DSPMC_NET_RDS, 2'h2});
    end
    $display("network test done");
  endtask : t_net
  task automatic t_shdn();
    dspmc_sw_model_i.set_pin(1'h0);
    tick();
    chk({app_mode, power_level, rtc_run, aon_power_en, net_mode},
      {DSPMC_APP_SHUTDOWN, PWR_OFF, 2'h0, DSPMC_NET_DISABLED});
    dspmc_sw_model_i.request(DSPMC_REQ_SLEEP);
    chk(app_mode, DSPMC_APP_SHUTDOWN);
    dspmc_sw_model_i.set_pin(1'h1);
    t_boot();
    $display("shutdown test done");
  endtask : t_shdn
  initial begin
    {sleep_timer_wake_en, sleep_periph_wake_en, rds_rtc_wake_en, hib_rtc_wake_en, fast_timer_expired} = '0;
    {periph_activity, rtc_expired, flash_reload_done, net_enable, net_power_save_en, net_ip_traffic} = '0;
    {net_link_traffic, beacon_due, frame_valid, frame_is_beacon, beacon_traffic_pending} = '0;
    {sleep_gpio_wake_mask, rds_gpio_wake_mask, hib_gpio_wake_mask, gpio_event, mem_retain_sel, cfg_live} = '0;
    sys_rst = 1'h1;
    tick(2);
    sys_rst = 1'h0;
    t_boot();
    t_sleep();
    t_rds();
    t_hib();
    t_net();
    t_shdn();
    end_of_test();
  end
  initial begin
    #(8 * 3000);
    errors++;
    end_of_test();
  end
endmodule : tb
